// ===== src/fspc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1 - Executing the suspend opcode 75h sets the read-only paused flag.
// RULE2 - Resume opcode 7Ah or power cycle clears the paused flag.
// RULE3 - Three security lock bits reset unlocked; each settable alone by status write.
// RULE4 - Lock bits never clear; a locked security register refuses program/erase. RST_I clears them here.
// RULE5 - Quad enable low keeps write-protect and hold; high makes them quad lines.
// RULE6 - Host never sets quad enable when those pins are strapped to rails.
// RULE7 - Scheme select one uses per-block locks; zero uses range decode.
// RULE8 - All individual block lock bits come up locked at reset.
// RULE9 - Drive field 00/01/10/11 gives 100/75/50/25 percent; default 11.
// RULE10 - Shared pin is hold when select bit is 0, reset when 1.
// RULE11 - Hold or reset applies only while quad enable is zero.
// RULE12 - Reserved bits ignore writes; they read back as zero here.
// RULE13 - Block codes protect none, 64KB doubling to 2MB, or all 4MB.
// RULE14 - Sector codes protect 4, 8, 16, 32KB; low bit ignored for 10x.
// RULE15 - Erase or program touching any protected byte is ignored whole.
// RULE16 - Top/bottom zero protects from the top, one from the bottom.
// RULE17 - Sector select one counts 4KB sectors, zero counts 64KB blocks.
// RULE18 - Complement inverts the decoded window across the array.
// RULE19 - Range check is combinational against start and end addresses.
module fspc_top
  import fspc_pkg::*;
#(
  parameter int NLOCK = fspc_pkg::NUM_LOCKS
)
(
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // Executed instruction strobe
  input wire logic OP_VALID_I,
  input wire logic [7:0] OP_CODE_I,
  // Status register writes, already qualified by enable/lock logic
  input wire logic SR2_WR_I,
  input wire logic SR3_WR_I,
  input wire logic [7:0] SR_WDATA_I,
  input wire logic [7:0] SR1_I,
  // Individual block lock access
  input wire logic LOCK_WR_I,
  input wire logic [6:0] LOCK_IDX_I,
  input wire logic LOCK_VAL_I,
  // Array and security-register write requests
  input wire logic CHK_VALID_I,
  input wire logic CHK_SECREG_I,
  input wire logic [1:0] CHK_SECREG_SEL_I,
  input wire logic [fspc_pkg::ADDR_W-1:0] CHK_START_I,
  input wire logic [fspc_pkg::ADDR_W-1:0] CHK_END_I,
  output logic CHK_ALLOW_O,
  output logic CHK_BLOCK_O,
  // Register views and pin function
  output logic [7:0] SR2_RDATA_O,
  output logic [7:0] SR3_RDATA_O,
  output logic [1:0] DRIVE_CODE_O,
  output logic WP_PIN_ACTIVE_O,
  output logic HOLD_ACTIVE_O,
  output logic RESET_PIN_ACTIVE_O,
  output logic QUAD_LINES_O
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic paused_flag;
    logic [2:0] otp_lock;
    logic quad_io_enable;
    logic srl;
    logic invert_protection;
    logic lock_scheme_select;
    logic drive_strength_hi;
    logic drive_strength_lo;
    logic hold_reset_sel;
    logic [NLOCK-1:0] blk_lock;
    logic allow;
    logic block;
  } fspc_state_type;

  fspc_state_type st_q;
  fspc_state_type st_d;

  logic win_valid;
  logic [ADDR_W-1:0] win_lo;
  logic [ADDR_W-1:0] win_hi;
  logic overlap;
  logic range_hit;
  logic lock_hit;
  logic [6:0] first_idx;
  logic [6:0] last_idx;

  // ---------------------------------------------------------------
  // Protection window
  // ---------------------------------------------------------------
  fspc_range_dec u_dec
  (
    .sector_granularity_i(SR1_I[6]),
    .top_bottom_select_i(SR1_I[5]),
    .protect_range_i(SR1_I[4:2]),
    .win_valid_o(win_valid),
    .win_lo_o(win_lo),
    .win_hi_o(win_hi)
  );

  // ---------------------------------------------------------------
  // Individual lock map
  // ---------------------------------------------------------------
  // Map an address to its individual lock: sectors in edge blocks
  function automatic logic [6:0] lock_index(input logic [ADDR_W-1:0] a);
    logic [5:0] blk;
    blk = a[ADDR_W-1:BLOCK_SHIFT];
    if (blk == 6'd0)
      lock_index = 7'(a[BLOCK_SHIFT-1:SECTOR_SHIFT]);
    else if (blk == 6'(NUM_BLOCKS-1))
      lock_index = 7'(NUM_SECTORS_EDGE + NUM_BLOCKS - 2) + 7'(a[BLOCK_SHIFT-1:SECTOR_SHIFT]);
    else
      lock_index = 7'(NUM_SECTORS_EDGE - 1) + 7'(blk);
  endfunction : lock_index

  // ---------------------------------------------------------------
  // Protection check
  // ---------------------------------------------------------------
  always_comb
  begin
    overlap = win_valid && !(CHK_END_I < win_lo || CHK_START_I > win_hi); // RULE19
    // Complement: any byte outside the window counts as protected
    if (st_q.invert_protection)
      range_hit = !win_valid || (CHK_START_I < win_lo) || (CHK_END_I > win_hi); // RULE18
    else
      range_hit = overlap;
    first_idx = lock_index(CHK_START_I);
    last_idx = lock_index(CHK_END_I);
    // Full scan keeps the lock map in one function, at some area cost
    lock_hit = 1'b0;
    for (int i = 0; i < NLOCK; i++)
    begin
      if (7'(i) >= first_idx && 7'(i) <= last_idx && st_q.blk_lock[i])
        lock_hit = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.allow = 1'b0;
    st_d.block = 1'b0;
    if (OP_VALID_I && OP_CODE_I == OP_SUSPEND)
      st_d.paused_flag = 1'b1; // RULE1
    else if (OP_VALID_I && OP_CODE_I == OP_RESUME)
      st_d.paused_flag = 1'b0; // RULE2
    // Status-only and reserved positions never take write data
    if (SR2_WR_I)
    begin
      // OTP bits only ever OR in
      st_d.otp_lock = st_q.otp_lock | SR_WDATA_I[SR2_LOCK_THREE:SR2_LOCK_ONE]; // RULE3 RULE4
      st_d.quad_io_enable = SR_WDATA_I[SR2_QUAD_EN]; // RULE5
      st_d.srl = SR_WDATA_I[SR2_SRL];
      st_d.invert_protection = SR_WDATA_I[SR2_INVERT];
    end
    if (SR3_WR_I)
    begin
      st_d.lock_scheme_select = SR_WDATA_I[SR3_SCHEME]; // RULE7
      st_d.drive_strength_hi = SR_WDATA_I[SR3_DRV_HI]; // RULE9
      st_d.drive_strength_lo = SR_WDATA_I[SR3_DRV_LO];
      st_d.hold_reset_sel = SR_WDATA_I[SR3_HOLDRST]; // RULE10
    end
    if (LOCK_WR_I && 32'(LOCK_IDX_I) < NLOCK)
      st_d.blk_lock[LOCK_IDX_I] = LOCK_VAL_I;
    if (CHK_VALID_I)
    begin
      if (CHK_SECREG_I)
        st_d.block = (CHK_SECREG_SEL_I != 2'd0) && st_q.otp_lock[CHK_SECREG_SEL_I - 2'd1]; // RULE4
      else if (st_q.lock_scheme_select)
        st_d.block = lock_hit; // RULE7
      else
        st_d.block = range_hit; // RULE15
      st_d.allow = !st_d.block;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Power cycle and device reset both land here
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      st_q <= '0;
      st_q.otp_lock <= SR2_RESET[SR2_LOCK_THREE:SR2_LOCK_ONE]; // RULE3
      st_q.quad_io_enable <= SR2_RESET[SR2_QUAD_EN];
      st_q.lock_scheme_select <= SR3_RESET[SR3_SCHEME];
      st_q.hold_reset_sel <= SR3_RESET[SR3_HOLDRST]; // RULE10
      st_q.drive_strength_hi <= SR3_RESET[SR3_DRV_HI]; // RULE9
      st_q.drive_strength_lo <= SR3_RESET[SR3_DRV_LO];
      st_q.blk_lock <= '1; // RULE8
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign CHK_ALLOW_O = st_q.allow;
  assign CHK_BLOCK_O = st_q.block;
  // Reserved positions read zero
  assign SR2_RDATA_O = {st_q.paused_flag, st_q.invert_protection, st_q.otp_lock,
                        1'b0, st_q.quad_io_enable, st_q.srl}; // RULE12
  assign SR3_RDATA_O = {st_q.hold_reset_sel, st_q.drive_strength_hi, st_q.drive_strength_lo,
                        2'b00, st_q.lock_scheme_select, 2'b00};
  assign DRIVE_CODE_O = {st_q.drive_strength_hi, st_q.drive_strength_lo};
  // Quad mode hands both shared pins to the data path
  assign QUAD_LINES_O = st_q.quad_io_enable; // RULE5
  assign WP_PIN_ACTIVE_O = !st_q.quad_io_enable;
  assign HOLD_ACTIVE_O = !st_q.quad_io_enable && !st_q.hold_reset_sel; // RULE11
  assign RESET_PIN_ACTIVE_O = !st_q.quad_io_enable && st_q.hold_reset_sel; // RULE11
endmodule : fspc_top
`default_nettype wire

// ===== inc/fspc_pkg.sv
`default_nettype none
package fspc_pkg;
  // ---------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 22;
  localparam int SECTOR_SHIFT = 12;
  localparam int BLOCK_SHIFT = 16;
  localparam int NUM_BLOCKS = 64;
  localparam int NUM_SECTORS_EDGE = 16;
  localparam int NUM_LOCKS = 94;
  localparam int SECREG_W = 8;

  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;

  // ---------------------------------------------------------------
  // Second status register bit positions (S8..S15 -> 0..7)
  // ---------------------------------------------------------------
  localparam int SR2_SRL = 0;
  localparam int SR2_QUAD_EN = 1;
  localparam int SR2_RSVD = 2;
  localparam int SR2_LOCK_ONE = 3;
  localparam int SR2_LOCK_TWO = 4;
  localparam int SR2_LOCK_THREE = 5;
  localparam int SR2_INVERT = 6;
  localparam int SR2_PAUSED = 7;
  localparam logic [7:0] SR2_WR_MASK = 8'h7A;
  localparam logic [7:0] SR2_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Third status register bit positions (S16..S23 -> 0..7)
  // ---------------------------------------------------------------
  localparam int SR3_SCHEME = 2;
  localparam int SR3_DRV_LO = 5;
  localparam int SR3_DRV_HI = 6;
  localparam int SR3_HOLDRST = 7;
  localparam logic [7:0] SR3_WR_MASK = 8'hE4;
  localparam logic [7:0] SR3_RESET = 8'h60;

  // Drive strength codes (percent of full drive)
  localparam logic [1:0] DRV_100 = 2'h0;
  localparam logic [1:0] DRV_75 = 2'h1;
  localparam logic [1:0] DRV_50 = 2'h2;
  localparam logic [1:0] DRV_25 = 2'h3;

  // Protection kept in the first status register
  localparam logic [2:0] BP_NONE = 3'h0;
  localparam logic [2:0] BP_ALL = 3'h7;
endpackage : fspc_pkg
`default_nettype wire

// ===== src/fspc_range_dec.sv
`timescale 1ns/1ps
`default_nettype none
// Decodes the protection bits into an inclusive address window.
module fspc_range_dec
  import fspc_pkg::*;
(
  input wire logic sector_granularity_i,
  input wire logic top_bottom_select_i,
  input wire logic [2:0] protect_range_i,
  output logic win_valid_o,
  output logic [fspc_pkg::ADDR_W-1:0] win_lo_o,
  output logic [fspc_pkg::ADDR_W-1:0] win_hi_o
);
  logic [ADDR_W:0] size;
  logic [ADDR_W-1:0] top;

  always_comb
  begin
    size = '0;
    win_valid_o = 1'b1;
    top = '1;
    if (protect_range_i == BP_NONE)
    begin
      win_valid_o = 1'b0;
    end
    else if (protect_range_i == BP_ALL)
    begin
      size = (ADDR_W+1)'(1) << ADDR_W; // RULE13
    end
    else if (sector_granularity_i)
    begin
      // Low code bit ignored once the top bit is set
      if (protect_range_i[2])
        size = (ADDR_W+1)'(1) << (SECTOR_SHIFT + 3); // RULE14
      else
        size = (ADDR_W+1)'(1) << (SECTOR_SHIFT + 32'(protect_range_i) - 1); // RULE17
    end
    else
    begin
      size = (ADDR_W+1)'(1) << (BLOCK_SHIFT + 32'(protect_range_i) - 1); // RULE13
    end
    // Top end by default, bottom end when selected
    if (top_bottom_select_i)
    begin
      win_lo_o = '0; // RULE16
      win_hi_o = ADDR_W'(size - 1);
    end
    else
    begin
      win_hi_o = top;
      win_lo_o = ADDR_W'((ADDR_W+1)'(1 << ADDR_W) - size);
    end
  end
endmodule : fspc_range_dec
`default_nettype wire

// ===== tb/fspc_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fspc_top_properties (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic OP_VALID_I,
  input wire logic [7:0] OP_CODE_I,
  input wire logic CHK_VALID_I,
  input wire logic CHK_SECREG_I,
  input wire logic [1:0] CHK_SECREG_SEL_I,
  input wire logic CHK_ALLOW_O,
  input wire logic CHK_BLOCK_O,
  input wire logic [7:0] SR2_RDATA_O,
  input wire logic [7:0] SR3_RDATA_O,
  input wire logic [1:0] DRIVE_CODE_O,
  input wire logic WP_PIN_ACTIVE_O,
  input wire logic HOLD_ACTIVE_O,
  input wire logic RESET_PIN_ACTIVE_O,
  input wire logic QUAD_LINES_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_suspend; OP_VALID_I && OP_CODE_I == 8'h75; endsequence
  sequence s_resume; OP_VALID_I && OP_CODE_I == 8'h7A; endsequence
  sequence s_locked_req; CHK_VALID_I && CHK_SECREG_I && CHK_SECREG_SEL_I != 2'h0; endsequence
  property p_paused_set; s_suspend |=> SR2_RDATA_O[7]; endproperty
  property p_paused_clr; s_resume |=> !SR2_RDATA_O[7]; endproperty
  property p_lock_keep; 1'b1 |=> (SR2_RDATA_O[5:3] & $past(SR2_RDATA_O[5:3])) == $past(SR2_RDATA_O[5:3]); endproperty
  property p_secreg_block; s_locked_req ##0 SR2_RDATA_O[2 + CHK_SECREG_SEL_I] |=> CHK_BLOCK_O; endproperty
  property p_answer; CHK_VALID_I |=> CHK_ALLOW_O != CHK_BLOCK_O; endproperty
  property p_idle; !CHK_VALID_I |=> !(CHK_ALLOW_O || CHK_BLOCK_O); endproperty
  property p_pins; QUAD_LINES_O == SR2_RDATA_O[1] && WP_PIN_ACTIVE_O == !SR2_RDATA_O[1]; endproperty
  property p_hold_rst; HOLD_ACTIVE_O == (!SR2_RDATA_O[1] && !SR3_RDATA_O[7]) && RESET_PIN_ACTIVE_O == (!SR2_RDATA_O[1] && SR3_RDATA_O[7]); endproperty
  property p_drive; DRIVE_CODE_O == SR3_RDATA_O[6:5]; endproperty
  property p_rsvd; !SR2_RDATA_O[2] && (SR3_RDATA_O & 8'h1B) == 8'h00; endproperty
  a_paused_set: assert property (p_paused_set) else $error("paused flag not set");
  a_paused_clr: assert property (p_paused_clr) else $error("paused flag not cleared");
  a_lock_keep: assert property (p_lock_keep) else $error("lock bit returned to zero");
  a_secreg_block: assert property (p_secreg_block) else $error("locked security write passed");
  a_answer: assert property (p_answer) else $error("check answer missing");
  a_idle: assert property (p_idle) else $error("spurious check answer");
  a_pins: assert property (p_pins) else $error("quad pin function wrong");
  a_hold_rst: assert property (p_hold_rst) else $error("shared pin function wrong");
  a_drive: assert property (p_drive) else $error("drive code mismatch");
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
endmodule : fspc_top_properties
bind fspc_top fspc_top_properties fspc_top_properties_inst (.REF_CLK_I, .RST_I, .OP_VALID_I,
  .OP_CODE_I, .CHK_VALID_I, .CHK_SECREG_I, .CHK_SECREG_SEL_I, .CHK_ALLOW_O, .CHK_BLOCK_O,
  .SR2_RDATA_O, .SR3_RDATA_O, .DRIVE_CODE_O, .WP_PIN_ACTIVE_O, .HOLD_ACTIVE_O,
  .RESET_PIN_ACTIVE_O, .QUAD_LINES_O);
`default_nettype wire

// ===== tb/fspc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fspc_host_model
  import fspc_pkg::*;
#(
  parameter bit PINS_TIED = 1'b0
)
(
  input wire logic clk_i,
  input wire logic block_i,
  output logic op_valid_o,
  output logic [7:0] op_code_o,
  output logic sr2_wr_o,
  output logic sr3_wr_o,
  output logic [7:0] wdata_o,
  output logic chk_valid_o,
  output logic chk_secreg_o,
  output logic [1:0] chk_sel_o,
  output logic [fspc_pkg::ADDR_W-1:0] chk_start_o,
  output logic [fspc_pkg::ADDR_W-1:0] chk_end_o
);
  initial {op_valid_o, op_code_o, sr2_wr_o, sr3_wr_o, wdata_o} = '0;
  initial {chk_valid_o, chk_secreg_o, chk_sel_o, chk_start_o, chk_end_o} = '0;
  // Kind 0 runs an opcode, 1 and 2 write the second and third register
  task automatic pulse(input int kind, input logic [7:0] d);
    @(negedge clk_i);
    // Strapped pins would fight the quad data drivers
    if (kind == 1 && PINS_TIED) d[1] = 1'b0;
    op_code_o = d;
    wdata_o = d;
    op_valid_o = (kind == 0);
    sr2_wr_o = (kind == 1);
    sr3_wr_o = (kind == 2);
    @(negedge clk_i);
    {op_valid_o, sr2_wr_o, sr3_wr_o} = '0;
  endtask : pulse
  task automatic chk(input logic sr, input logic [1:0] sel, input logic [ADDR_W-1:0] s,
    input logic [ADDR_W-1:0] e, output logic blk);
    @(negedge clk_i);
    {chk_valid_o, chk_secreg_o, chk_sel_o, chk_start_o, chk_end_o} = {1'b1, sr, sel, s, e};
    @(negedge clk_i);
    blk = block_i;
    chk_valid_o = 1'b0;
  endtask : chk
endmodule : fspc_host_model
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module testbench;
  import fspc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic lock_wr = 1'b0;
  logic [6:0] lock_idx = '0;
  logic lock_val = 1'b0;
  logic [7:0] sr1 = '0;
  logic op_valid, sr2_wr, sr3_wr, chk_valid, chk_secreg, allow, block, wp, hold, rpin, quad, blk;
  logic [7:0] op_code, wdata, sr2, sr3;
  logic [1:0] chk_sel, drive;
  logic [ADDR_W-1:0] chk_start, chk_end, sz, in_a, out_a;
  int err_total = 0;
  int num_checks = 0;
  fspc_host_model fspc_host_model_inst (.clk_i(ref_clk), .block_i(block), .op_valid_o(op_valid),
    .op_code_o(op_code), .sr2_wr_o(sr2_wr), .sr3_wr_o(sr3_wr), .wdata_o(wdata),
    .chk_valid_o(chk_valid), .chk_secreg_o(chk_secreg), .chk_sel_o(chk_sel),
    .chk_start_o(chk_start), .chk_end_o(chk_end));
  fspc_top fspc_top_inst (.REF_CLK_I(ref_clk), .RST_I(rst), .OP_VALID_I(op_valid),
    .OP_CODE_I(op_code), .SR2_WR_I(sr2_wr), .SR3_WR_I(sr3_wr), .SR_WDATA_I(wdata),
    .SR1_I(sr1), .LOCK_WR_I(lock_wr), .LOCK_IDX_I(lock_idx), .LOCK_VAL_I(lock_val),
    .CHK_VALID_I(chk_valid), .CHK_SECREG_I(chk_secreg), .CHK_SECREG_SEL_I(chk_sel),
    .CHK_START_I(chk_start), .CHK_END_I(chk_end), .CHK_ALLOW_O(allow), .CHK_BLOCK_O(block),
    .SR2_RDATA_O(sr2), .SR3_RDATA_O(sr3), .DRIVE_CODE_O(drive), .WP_PIN_ACTIVE_O(wp),
    .HOLD_ACTIVE_O(hold), .RESET_PIN_ACTIVE_O(rpin), .QUAD_LINES_O(quad));
  initial forever #4 ref_clk = ~ref_clk;
  function automatic logic [ADDR_W-1:0] wsize(input logic s, input logic [2:0] b);
    wsize = s ? (22'h00_1000 << (b[2] ? 3 : b - 1)) : (22'h01_0000 << (b - 1));
  endfunction : wsize
  task final_report;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  // Guards against a stuck sequence
  initial
  begin
    repeat (50000) @(posedge ref_clk);
    err_total++;
    final_report();
  end
  initial
  begin
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    `CHK("sr2 reset", 8'h00, sr2)
    `CHK("sr3 reset", 8'h60, sr3)
    `CHK("hold reset", 1'b1, hold)
    fspc_host_model_inst.pulse(0, 8'h75);
    `CHK("suspend", 8'h80, sr2)
    fspc_host_model_inst.pulse(1, 8'h08);
    `CHK("lock one", 8'h88, sr2)
    fspc_host_model_inst.pulse(1, 8'h84);
    `CHK("lock kept", 8'h88, sr2)
    fspc_host_model_inst.pulse(0, 8'h7A);
    `CHK("resume", 8'h08, sr2)
    fspc_host_model_inst.chk(1'b1, 2'h1, 22'h00_0000, 22'h00_00FF, blk);
    `CHK("secreg1", 1'b1, blk)
    `CHK("secreg1 allow", 1'b0, allow)
    fspc_host_model_inst.chk(1'b1, 2'h3, 22'h00_0000, 22'h00_00FF, blk);
    `CHK("secreg3", 1'b0, blk)
    `CHK("secreg3 allow", 1'b1, allow)
    fspc_host_model_inst.pulse(1, 8'h02);
    `CHK("quad on", 3'b100, {quad, wp, hold})
    fspc_host_model_inst.pulse(2, 8'hE0);
    `CHK("reset pin qe", 1'b0, rpin)
    fspc_host_model_inst.pulse(1, 8'h00);
    `CHK("reset pin", 4'b0101, {quad, wp, hold, rpin})
    for (int d = 0; d < 4; d++)
    begin
      fspc_host_model_inst.pulse(2, {1'b0, 2'(d), 5'h00});
      `CHK("drive", 2'(d), drive)
    end
    for (int c = 0; c < 2; c++)
    begin
      fspc_host_model_inst.pulse(1, {1'b0, 1'(c), 6'h00});
      for (int s = 0; s < 2; s++)
        for (int t = 0; t < 2; t++)
          for (int b = 0; b < 8; b++)
          begin
            sr1 = {1'b0, 1'(s), 1'(t), 3'(b), 2'h0};
            if (b == 0 || b == 7)
            begin
              fspc_host_model_inst.chk(1'b0, 2'h0, 22'h12_3456, 22'h12_3456, blk);
              `CHK("none or all", (b == 7) ^ (c == 1), blk)
              continue;
            end
            if (s == 1 && b == 6) continue;
            sz = wsize(1'(s), 3'(b));
            in_a = t ? sz - 22'h00_0001 : 22'h00_0000 - sz;
            out_a = t ? sz : in_a - 22'h00_0001;
            fspc_host_model_inst.chk(1'b0, 2'h0, in_a, in_a, blk);
            `CHK("inside", c == 0, blk)
            fspc_host_model_inst.chk(1'b0, 2'h0, out_a, out_a, blk);
            `CHK("outside", c == 1, blk)
            fspc_host_model_inst.chk(1'b0, 2'h0, t ? in_a : out_a, t ? out_a : in_a,
              blk);
            `CHK("straddle", 1'b1, blk)
          end
    end
    sr1 = 8'h00;
    fspc_host_model_inst.pulse(1, 8'h00);
    fspc_host_model_inst.pulse(2, 8'h7F);
    `CHK("sr3 write", 8'h64, sr3)
    fspc_host_model_inst.chk(1'b0, 2'h0, 22'h05_0000, 22'h05_0000, blk);
    `CHK("all locked", 1'b1, blk)
    @(negedge ref_clk);
    {lock_wr, lock_idx, lock_val} = {1'b1, 7'h14, 1'b0};
    @(negedge ref_clk);
    lock_wr = 1'b0;
    fspc_host_model_inst.chk(1'b0, 2'h0, 22'h05_0000, 22'h05_FFFF, blk);
    `CHK("unlocked", 1'b0, blk)
    `CHK("unlocked allow", 1'b1, allow)
    fspc_host_model_inst.chk(1'b0, 2'h0, 22'h05_FFFF, 22'h06_0000, blk);
    `CHK("span lock", 1'b1, blk)
    final_report();
  end
endmodule : testbench
`default_nettype wire
